// ### dv/pci_target_config_space_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module pci_target_config_space_bench;
   logic        sys_clk, rst, frame_n, irdy_n, idsel, par_in, sda_in, par_out, par_oe, ad_oe;
   logic        trdy_n, devsel_n, stop_n, tctl_oe, perr_n, perr_oe, sda_out, sda_oe, scl_out;
   logic        scl_oe, win_wr, win_rd, master_abort_evt, target_abort_evt, bus_master_en;
   logic        fast_b2b_en, preload_busy, perr_seen;
   logic [3:0]  cbe_n, win_be, wbe;
   logic [6:0]  win_index, widx;
   logic [7:0]  latency_timer, ee_byte, a;
   logic [31:0] ad_in, ad_out, win_wdata, win_rdata, wdat, q;
   logic [1:0]  r;
   int          mismatches, num_checks;
   pcicfg_target dut (.*);
   pcicfg_eeprom_model u_ee (.rst(rst), .sda_oe(sda_oe), .scl_oe(scl_oe), .sda_in(sda_in),
                             .first_byte(ee_byte));
   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Window traffic and parity error capture
   always @(posedge sys_clk) begin
      if (win_wr || win_rd) widx <= win_index;
      if (win_wr) {wbe, wdat} <= {win_be, win_wdata};
      if (!perr_n) perr_seen <= 1'b1;
   end
   // One transfer; r: 0 no claim, 1 data, 2 retry
   task automatic xfer(input logic [3:0] c, input logic [31:0] ad, d, input logic [3:0] be,
                       input logic bap, bdp);
      r = 2'd0;
      @(negedge sys_clk);
      frame_n = 1'b0;
      idsel   = (c == pcicfg_pkg::BC_CFG_RD) || (c == pcicfg_pkg::BC_CFG_WR);
      ad_in   = ad;
      cbe_n   = c;
      @(negedge sys_clk);
      par_in  = ^{ad, c} ^ bap;
      frame_n = 1'b1;
      irdy_n  = 1'b0;
      ad_in   = d;
      cbe_n   = ~be;
      for (int n = 0; n < 12 && r == 2'd0; n++) begin
         @(negedge sys_clk);
         par_in = ^{d, ~be} ^ bdp;
         if (trdy_n === 1'b0) begin
            r = 2'd1;
            q = ad_out;
         end else if (stop_n === 1'b0) r = 2'd2;
      end
      irdy_n = 1'b1;
      ad_in  = ~d;
      cbe_n  = 4'hF;
      idsel  = 1'b0;
      repeat (5) @(negedge sys_clk);
   endtask : xfer
   task automatic cfg(input logic [7:0] o, input logic [31:0] wv, exp);
      xfer(pcicfg_pkg::BC_CFG_WR, {24'h0, o}, wv, 4'hF, 1'b0, 1'b0);
      xfer(pcicfg_pkg::BC_CFG_RD, {24'h0, o}, 32'h0, 4'hF, 1'b0, 1'b0);
      `CHECK("config word", {2'd1, exp}, {r, q})
   endtask : cfg
   task automatic complete_run;
      if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   // Watchdog
   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      complete_run();
   end
   // Main sequence
   initial begin
      rst = 1; frame_n = 1; irdy_n = 1; idsel = 0; par_in = 0; cbe_n = 4'hF; ad_in = 0;
      master_abort_evt = 0; target_abort_evt = 0; win_rdata = 32'h1234_5678; perr_seen = 0;
      repeat (20) @(negedge sys_clk);
      rst = 0;
      xfer(pcicfg_pkg::BC_CFG_RD, 32'h0, 32'h0, 4'hF, 1'b0, 1'b0);
      `CHECK("early access", 2'd2, r)
      for (int n = 0; n < 40000 && preload_busy !== 1'b0; n++) @(negedge sys_clk);
      `CHECK("preload end", 1'b0, preload_busy)
      `CHECK("eeprom address", 8'hA0, ee_byte)
      cfg(8'h00, 32'hFFFF_FFFF, {pcicfg_pkg::DEVICE_CODE, pcicfg_pkg::VENDOR_CODE});
      cfg(8'h08, 32'hFFFF_FFFF, {24'h048000, pcicfg_pkg::REVISION});
      cfg(8'h0C, 32'hFFFF_FFFF, 32'h0000_FF00);
      `CHECK("latency", 8'hFF, latency_timer)
      xfer(pcicfg_pkg::BC_CFG_WR, 32'h0C, 32'h0000_1100, 4'h1, 1'b0, 1'b0);
      `CHECK("latency lanes", 8'hFF, latency_timer)
      cfg(8'h0C, 32'h0000_0000, 32'h0000_0000);
      cfg(8'h10, 32'hFFFF_FFFF, 32'hFFFF_FE00);
      cfg(8'h2C, 32'hFFFF_FFFF, 32'h0000_0000);
      cfg(8'h3C, 32'hFFFF_FFFF, 32'h260F_01FF);
      for (a = 8'h14; a < 8'h3C; a += 8'h04) if (a != 8'h2C) cfg(a, 32'hFFFF_FFFF, 32'h0);
      cfg(8'h10, 32'h1000_0000, 32'h1000_0000);
      cfg(8'h04, 32'h0000_0246, 32'h0280_0246);
      `CHECK("master and fast enables", 2'b11, {bus_master_en, fast_b2b_en})
      for (int i = 0; i < 3; i++) begin
         xfer((i == 0) ? pcicfg_pkg::BC_MEM_RD : (i == 1) ? pcicfg_pkg::BC_MEM_RDM : pcicfg_pkg::BC_MEM_RDL,
              32'h1000_0008, 32'h0, 4'hF, 1'b0, 1'b0);
         `CHECK("window read", {2'd1, 32'h1234_5678, 7'h02}, {r, q, widx})
      end
      xfer(pcicfg_pkg::BC_MEM_WR, 32'h1000_0010, 32'hA5A5_0001, 4'h6, 1'b0, 1'b0);
      `CHECK("window write lanes", {4'h6, 32'hA5A5_0001, 7'h04}, {wbe, wdat, widx})
      xfer(pcicfg_pkg::BC_MEM_WRI, 32'h1000_01FC, 32'h5A5A_0002, 4'hF, 1'b0, 1'b0);
      `CHECK("window write", {32'h5A5A_0002, 7'h7F}, {wdat, widx})
      xfer(pcicfg_pkg::BC_MEM_RD, 32'h2000_0000, 32'h0, 4'hF, 1'b0, 1'b0);
      `CHECK("foreign address", 2'd0, r)
      xfer(pcicfg_pkg::BC_MEM_RD, 32'h1000_0000, 32'h0, 4'hF, 1'b1, 1'b0);
      `CHECK("bad address parity", 2'd0, r)
      cfg(8'h04, 32'h0000_0246, 32'h8280_0246);
      cfg(8'h04, 32'h8000_0246, 32'h0280_0246);
      xfer(pcicfg_pkg::BC_MEM_WR, 32'h1000_0004, 32'h0000_0003, 4'hF, 1'b0, 1'b1);
      `CHECK("parity error pin", 1'b1, perr_seen)
      cfg(8'h04, 32'h8100_0246, 32'h0280_0246);
      @(negedge sys_clk);
      master_abort_evt = 1;
      target_abort_evt = 1;
      @(negedge sys_clk);
      master_abort_evt = 0;
      target_abort_evt = 0;
      cfg(8'h04, 32'h0000_0246, 32'h3280_0246);
      complete_run();
   end
endmodule : pci_target_config_space_bench
`default_nettype wire

// ### dv/pcicfg_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcicfg_eeprom_model (
   // Reset and open-drain lines
   input  wire logic       rst,
   input  wire logic       sda_oe,
   input  wire logic       scl_oe,
   // Wire level and first byte seen
   output logic            sda_in,
   output logic      [7:0] first_byte
);
   logic [3:0] nbits;    // Bits shifted since reset
   logic       started;  // Start condition seen on the wire
   // Pull-up only: no part answers, so every ack reads high
   assign sda_in = ~sda_oe;
   // Start: data pulled low while the clock line is released
   always @(posedge sda_oe or posedge rst) begin
      if (rst) begin
         started <= 1'b0;
      end else if (!scl_oe) begin
         started <= 1'b1;
      end
   end
   // Capture the address byte at clock rise after the start
   always @(negedge scl_oe or posedge rst) begin
      if (rst) begin
         nbits <= 4'h0;
      end else if (started && nbits < 4'h8) begin
         first_byte <= {first_byte[6:0], sda_in};
         nbits      <= nbits + 4'h1;
      end
   end
endmodule : pcicfg_eeprom_model
`default_nettype wire

// ### dv/pcicfg_target_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcicfg_props (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // Bus pins
   input wire logic        frame_n,
   input wire logic [3:0]  cbe_n,
   input wire logic [31:0] ad_in,
   input wire logic        par_in,
   input wire logic        trdy_n,
   input wire logic        devsel_n,
   input wire logic        stop_n,
   input wire logic        tctl_oe,
   input wire logic        perr_n,
   input wire logic        perr_oe,
   // Window and preload
   input wire logic        win_wr,
   input wire logic        win_rd,
   input wire logic        preload_busy
);
   logic ap_q;  // Parity of the previous cycle's address and command
   // Expected address parity, one cycle behind
   always_ff @(posedge sys_clk) begin
      ap_q <= ^{ad_in, cbe_n};
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence addr_start;
      $fell(frame_n);
   endsequence
   sequence addr_bad;
      addr_start ##1 (par_in != ap_q);
   endsequence
   addr_parity_a: assert property (addr_bad |-> devsel_n [*8])
      else $error("claim after bad address parity");
   perr_pulse_a: assert property (!perr_n |=> perr_n)
      else $error("parity error pulse too long");
   perr_drive_a: assert property (!perr_n |-> perr_oe)
      else $error("parity error not driven");
   trdy_claim_a: assert property (!trdy_n |-> !devsel_n && tctl_oe ##1 trdy_n)
      else $error("data phase without claim or too long");
   retry_shape_a: assert property (preload_busy && !stop_n |-> trdy_n)
      else $error("data moved during preload");
   preload_quiet_a: assert property (preload_busy |-> !win_wr && !win_rd)
      else $error("window access during preload");
   window_claim_a: assert property (win_wr || win_rd |-> ##[0:4] !devsel_n)
      else $error("window access without claim");
   win_pulse_a: assert property (win_wr |=> !win_wr)
      else $error("window write longer than one cycle");
   devsel_drive_a: assert property (!devsel_n |-> tctl_oe)
      else $error("claim not driven");
endmodule : pcicfg_props
bind pcicfg_target pcicfg_props u_props (
   .sys_clk      (sys_clk),
   .rst          (rst),
   .frame_n      (frame_n),
   .cbe_n        (cbe_n),
   .ad_in        (ad_in),
   .par_in       (par_in),
   .trdy_n       (trdy_n),
   .devsel_n     (devsel_n),
   .stop_n       (stop_n),
   .tctl_oe      (tctl_oe),
   .perr_n       (perr_n),
   .perr_oe      (perr_oe),
   .win_wr       (win_wr),
   .win_rd       (win_rd),
   .preload_busy (preload_busy)
);
`default_nettype wire

// ### verilog/pcicfg_pkg.sv
`default_nettype none
package pcicfg_pkg;
   // Configuration header word offsets
   localparam logic [7:0]  OFS_IDENT   = 8'h00;
   localparam logic [7:0]  OFS_STCMD   = 8'h04;
   localparam logic [7:0]  OFS_CLASS   = 8'h08;
   localparam logic [7:0]  OFS_LATENCY = 8'h0C;
   localparam logic [7:0]  OFS_WINBASE = 8'h10;
   localparam logic [7:0]  OFS_SUBSYS  = 8'h2C;
   localparam logic [7:0]  OFS_GNTLAT  = 8'h3C;
   // Status and command bit positions
   localparam int          ST_DET_PERR = 31;
   localparam int          ST_RX_MABT  = 29;
   localparam int          ST_RX_TABT  = 28;
   localparam int          ST_DPERR    = 24;
   localparam int          CMD_FB2B    = 9;
   localparam int          CMD_PRESP   = 6;
   localparam int          CMD_MASTER  = 2;
   localparam int          CMD_MEM     = 1;
   // Fixed status bits: medium decode timing, fast back-to-back capable
   localparam logic [31:0] STATUS_FIXED = 32'h0280_0000;
   // Identity values, arbitrary
   localparam logic [15:0] DEVICE_CODE = 16'hA5C3;
   localparam logic [15:0] VENDOR_CODE = 16'h3C5A;
   localparam logic [7:0]  REVISION    = 8'h5A;
   // Class, interrupt pin (first pin) and loadable defaults
   localparam logic [23:0] CLASS_CODE  = 24'h048000;
   localparam logic [7:0]  INT_PIN_A   = 8'h01;
   localparam logic [7:0]  MAX_LAT_DEF = 8'h26;
   localparam logic [7:0]  MIN_GNT_DEF = 8'h0F;
   localparam logic [31:0] SUBSYS_DEF  = 32'h0000_0000;
   localparam int          WIN_LSB     = 9;
   // Bus commands
   localparam logic [3:0]  BC_CFG_RD   = 4'hA;
   localparam logic [3:0]  BC_CFG_WR   = 4'hB;
   localparam logic [3:0]  BC_MEM_RD   = 4'h6;
   localparam logic [3:0]  BC_MEM_WR   = 4'h7;
   localparam logic [3:0]  BC_MEM_RDM  = 4'hC;
   localparam logic [3:0]  BC_MEM_RDL  = 4'hE;
   localparam logic [3:0]  BC_MEM_WRI  = 4'hF;
   // Serial EEPROM preload
   localparam logic [6:0]  EE_DEV_ADDR = 7'b1010000;
   localparam logic [7:0]  EE_WORD_ADR = 8'h00;
   localparam logic [3:0]  EE_NBYTES   = 4'h6;
   localparam logic [3:0]  EE_STEP_RD0 = 4'h4;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          I2C_QTR_NS    = 2500;
   localparam logic [8:0]  I2C_QTR_CYC   = 9'((I2C_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Target transaction states
   typedef enum logic [2:0] {T_IDLE, T_DECODE, T_DATA, T_RETRY, T_END} pcicfg_tst_t;
   // Preload engine states
   typedef enum logic [2:0] {E_START, E_BIT, E_ACK, E_STOP, E_DONE} pcicfg_est_t;
endpackage : pcicfg_pkg
`default_nettype wire

// ### verilog/pcicfg_target.sv
`timescale 1ns/1ps
`default_nettype none
module pcicfg_target (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Bus control pins
   input  wire logic        frame_n,
   input  wire logic        irdy_n,
   input  wire logic        idsel,
   input  wire logic [3:0]  cbe_n,
   // Address/data and parity pins
   input  wire logic [31:0] ad_in,
   output logic      [31:0] ad_out,
   output logic             ad_oe,
   input  wire logic        par_in,
   output logic             par_out,
   output logic             par_oe,
   // Target response pins
   output logic             trdy_n,
   output logic             devsel_n,
   output logic             stop_n,
   output logic             tctl_oe,
   output logic             perr_n,
   output logic             perr_oe,
   // EEPROM serial pins
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             scl_out,
   output logic             scl_oe,
   // Register window port
   output logic             win_wr,
   output logic             win_rd,
   output logic      [6:0]  win_index,
   output logic      [31:0] win_wdata,
   output logic      [3:0]  win_be,
   input  wire logic [31:0] win_rdata,
   // Master side events and settings
   input  wire logic        master_abort_evt,
   input  wire logic        target_abort_evt,
   output logic             bus_master_en,
   output logic             fast_b2b_en,
   output logic      [7:0]  latency_timer,
   output logic             preload_busy
);
   // Pin synchronisers, two stages each, four for serial data
   logic [40:0] sync_a;                // First stage only feeds second
   logic [40:0] sync_b;                // Stage read by logic
   logic        sda_a, sda_s;          // Serial data synchroniser
   logic        frame_s, irdy_s, idsel_s, par_s;
   logic [3:0]  cbe_s;
   logic [31:0] ad_s;
   logic        frame_q;               // Frame one cycle ago

   // Latched address phase
   logic [31:0] adr_lat;
   logic [3:0]  cmd_lat;
   logic        idsel_lat;
   logic        ad_par_calc;           // Parity of address phase
   pcicfg_pkg::pcicfg_tst_t tst;       // Target state

   localparam int WIN_BASE_LSB = pcicfg_pkg::WIN_LSB; // Lowest writable base bit

   // Header storage
   logic [3:0]  status_err;            // Bits 31,29,28,24
   logic [9:0]  cmd_reg;               // Command low bits
   logic [31:WIN_BASE_LSB] win_base;
   logic [7:0]  int_line;
   logic [31:0] subsys;
   logic [7:0]  max_lat, min_gnt;

   // Write parity check pipeline
   logic        wchk_pend;
   logic        wchk_par;
   logic        next_perr;

   // Derived decode terms
   logic        addr_phase, is_cfg, is_mem_rd, is_mem_wr, is_rd, hit_mem, hit_cfg;
   logic [31:0] cfg_rdata;

   // Two flop synchronisers on all incoming pins, serial data gets two more
   always_ff @(posedge sys_clk) begin
      sync_a <= {frame_n, irdy_n, idsel, par_in, cbe_n, ad_in, sda_in};
      sync_b <= sync_a;
      sda_a  <= sync_b[0];
      sda_s  <= sda_a;
   end
   assign {frame_s, irdy_s, idsel_s, par_s, cbe_s, ad_s} = sync_b[40:1];

   // Frame history, starts released
   always_ff @(posedge sys_clk) begin
      if (rst) frame_q <= 1'b1;
      else     frame_q <= frame_s;
   end

   // Falling frame marks an address phase, even right after another frame
   assign addr_phase = frame_q & ~frame_s;

   // Command classes
   always_comb begin
      is_mem_rd = (cmd_lat == pcicfg_pkg::BC_MEM_RD) | (cmd_lat == pcicfg_pkg::BC_MEM_RDM)
                | (cmd_lat == pcicfg_pkg::BC_MEM_RDL);
      is_mem_wr = (cmd_lat == pcicfg_pkg::BC_MEM_WR) | (cmd_lat == pcicfg_pkg::BC_MEM_WRI);
      is_cfg    = (cmd_lat == pcicfg_pkg::BC_CFG_RD) | (cmd_lat == pcicfg_pkg::BC_CFG_WR);
      is_rd     = is_mem_rd | (cmd_lat == pcicfg_pkg::BC_CFG_RD);
      hit_cfg   = is_cfg & idsel_lat & (adr_lat[1:0] == 2'b00);
      hit_mem   = (is_mem_rd | is_mem_wr) & cmd_reg[pcicfg_pkg::CMD_MEM]
                & (adr_lat[31:WIN_BASE_LSB] == win_base);
   end

   // Address phase capture
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         adr_lat     <= 32'h0000_0000;
         cmd_lat     <= 4'h0;
         idsel_lat   <= 1'b0;
         ad_par_calc <= 1'b0;
      end else if (addr_phase) begin
         adr_lat     <= ad_s;
         cmd_lat     <= cbe_s;
         idsel_lat   <= idsel_s;
         ad_par_calc <= ^{ad_s, cbe_s};
      end
   end

   // Configuration read mux, absent words read zero
   always_comb begin
      case (adr_lat[7:0])
         pcicfg_pkg::OFS_IDENT:   cfg_rdata = {pcicfg_pkg::DEVICE_CODE, pcicfg_pkg::VENDOR_CODE};
         pcicfg_pkg::OFS_STCMD:   cfg_rdata = pcicfg_pkg::STATUS_FIXED
                                  | {status_err[3], 1'b0, status_err[2:1], 3'b000, status_err[0], 14'h0000,
                                     cmd_reg};
         pcicfg_pkg::OFS_CLASS:   cfg_rdata = {pcicfg_pkg::CLASS_CODE, pcicfg_pkg::REVISION};
         pcicfg_pkg::OFS_LATENCY: cfg_rdata = {16'h0000, latency_timer, 8'h00};
         pcicfg_pkg::OFS_WINBASE: cfg_rdata = {win_base, 9'h000};
         pcicfg_pkg::OFS_SUBSYS:  cfg_rdata = subsys;
         pcicfg_pkg::OFS_GNTLAT:  cfg_rdata = {max_lat, min_gnt, pcicfg_pkg::INT_PIN_A, int_line};
         default:                 cfg_rdata = 32'h0000_0000;
      endcase
   end

   // Target sequencer: claim, one data phase, disconnect
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tst      <= pcicfg_pkg::T_IDLE;
         devsel_n <= 1'b1;
         trdy_n   <= 1'b1;
         stop_n   <= 1'b1;
         tctl_oe  <= 1'b0;
         ad_out   <= 32'h0000_0000;
         ad_oe    <= 1'b0;
      end else begin
         case (tst)
            pcicfg_pkg::T_IDLE: begin
               // Released lines, wait for an address phase
               tctl_oe <= 1'b0;
               ad_oe   <= 1'b0;
               if (addr_phase) tst <= pcicfg_pkg::T_DECODE;
            end
            pcicfg_pkg::T_DECODE: begin
               // Parity now present for the address phase
               if ((par_s != ad_par_calc) || !(hit_cfg || hit_mem)) begin
                  tst <= pcicfg_pkg::T_IDLE;
               end else begin
                  devsel_n <= 1'b0;
                  tctl_oe  <= 1'b1;
                  tst      <= preload_busy ? pcicfg_pkg::T_RETRY : pcicfg_pkg::T_DATA;
               end
            end
            pcicfg_pkg::T_RETRY: begin
               // Stop without ready: the initiator must come back later
               stop_n <= 1'b0;
               tst    <= pcicfg_pkg::T_END;
            end
            pcicfg_pkg::T_DATA: begin
               // Read data goes out as ready falls
               if (is_rd) begin
                  ad_out <= hit_cfg ? cfg_rdata : win_rdata;
                  ad_oe  <= 1'b1;
               end
               if (!irdy_s) begin
                  trdy_n <= 1'b0;
                  stop_n <= 1'b0;
                  tst    <= pcicfg_pkg::T_END;
               end
            end
            pcicfg_pkg::T_END: begin
               // Hold until the initiator ends the frame, then drive high once
               if (frame_s && (!trdy_n || !stop_n)) begin
                  devsel_n <= 1'b1;
                  trdy_n   <= 1'b1;
                  stop_n   <= 1'b1;
                  ad_oe    <= 1'b0;
                  tst      <= pcicfg_pkg::T_IDLE;
               end else if (!trdy_n) begin
                  trdy_n <= 1'b1; // Single data phase taken
               end
            end
            default: tst <= pcicfg_pkg::T_IDLE;
         endcase
      end
   end

   // Read parity follows driven data by one cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         par_out <= 1'b0;
         par_oe  <= 1'b0;
      end else begin
         par_out <= ^{ad_out, cbe_s};
         par_oe  <= ad_oe;
      end
   end

   // Data phase taken: write and read strobes for the window
   logic data_take;
   assign data_take = (tst == pcicfg_pkg::T_DATA) & ~irdy_s;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         win_wr    <= 1'b0;
         win_rd    <= 1'b0;
         win_index <= 7'h00;
         win_wdata <= 32'h0000_0000;
         win_be    <= 4'h0;
      end else begin
         win_wr    <= data_take & hit_mem & is_mem_wr;
         win_rd    <= data_take & hit_mem & is_mem_rd;
         win_index <= adr_lat[8:2];
         win_wdata <= ad_s;
         win_be    <= ~cbe_s;
      end
   end

   // Configuration writes, byte lanes honoured
   logic cfg_wr;
   assign cfg_wr = data_take & hit_cfg & (cmd_lat == pcicfg_pkg::BC_CFG_WR);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_reg  <= 10'h000;
         latency_timer <= 8'h00;
         win_base <= '0;
         int_line <= 8'h00;
      end else if (cfg_wr) begin
         case (adr_lat[7:0])
            pcicfg_pkg::OFS_STCMD: begin
               if (!cbe_s[0]) begin
                  cmd_reg[pcicfg_pkg::CMD_PRESP]  <= ad_s[pcicfg_pkg::CMD_PRESP];
                  cmd_reg[pcicfg_pkg::CMD_MASTER] <= ad_s[pcicfg_pkg::CMD_MASTER];
                  cmd_reg[pcicfg_pkg::CMD_MEM]    <= ad_s[pcicfg_pkg::CMD_MEM];
               end
               if (!cbe_s[1]) cmd_reg[pcicfg_pkg::CMD_FB2B] <= ad_s[pcicfg_pkg::CMD_FB2B];
            end
            pcicfg_pkg::OFS_LATENCY: if (!cbe_s[1]) latency_timer <= ad_s[15:8];
            pcicfg_pkg::OFS_WINBASE: begin
               if (!cbe_s[1]) win_base[15:9]  <= ad_s[15:9];
               if (!cbe_s[2]) win_base[23:16] <= ad_s[23:16];
               if (!cbe_s[3]) win_base[31:24] <= ad_s[31:24];
            end
            pcicfg_pkg::OFS_GNTLAT:  if (!cbe_s[0]) int_line <= ad_s[7:0];
            default: ; // Read-only or absent words ignore writes
         endcase
      end
   end
   // Mirrors of command bits for the master side
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_master_en <= 1'b0;
         fast_b2b_en   <= 1'b0;
      end else begin
         bus_master_en <= cmd_reg[pcicfg_pkg::CMD_MASTER];
         fast_b2b_en   <= cmd_reg[pcicfg_pkg::CMD_FB2B];
      end
   end

   // Write data parity check one cycle after the data is taken
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wchk_pend <= 1'b0;
         wchk_par  <= 1'b0;
         perr_n    <= 1'b1;
         perr_oe   <= 1'b0;
      end else begin
         wchk_pend <= data_take & ~is_rd;
         wchk_par  <= ^{ad_s, cbe_s};
         perr_n    <= ~(next_perr & cmd_reg[pcicfg_pkg::CMD_PRESP]);
         perr_oe   <= (next_perr & cmd_reg[pcicfg_pkg::CMD_PRESP]) | ~perr_n;
      end
   end
   assign next_perr = wchk_pend & (par_s != wchk_par);

   // Sticky status error bits, write one to clear, set wins
   logic addr_perr;
   logic [3:0] st_set, st_clr;
   assign addr_perr = (tst == pcicfg_pkg::T_DECODE) & (par_s != ad_par_calc);
   always_comb begin
      st_set = {addr_perr | next_perr, master_abort_evt, target_abort_evt,
                next_perr & cmd_reg[pcicfg_pkg::CMD_PRESP]};
      st_clr = (cfg_wr && adr_lat[7:0] == pcicfg_pkg::OFS_STCMD && !cbe_s[3])
               ? {ad_s[pcicfg_pkg::ST_DET_PERR], ad_s[pcicfg_pkg::ST_RX_MABT],
                  ad_s[pcicfg_pkg::ST_RX_TABT], ad_s[pcicfg_pkg::ST_DPERR]} : 4'h0;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) status_err <= 4'h0;
      else     status_err <= (status_err & ~st_clr) | st_set;
   end

   // EEPROM preload engine: write word address, restart, read six bytes
   pcicfg_pkg::pcicfg_est_t est;
   logic [8:0] qcnt;                   // Quarter bit timer
   logic [1:0] qph;                    // Quarter within a bit
   logic [3:0] step;                   // Byte step of the sequence
   logic [2:0] bitn;                   // Bit within a byte
   logic [7:0] shreg;                  // Shift register
   logic       nacked;                 // Device failed to acknowledge
   logic       qtick;
   logic [47:0] ee_data;               // Received bytes
   assign qtick = (qcnt == pcicfg_pkg::I2C_QTR_CYC - 9'h001);

   always_ff @(posedge sys_clk) begin
      if (rst) qcnt <= 9'h000;
      else     qcnt <= qtick ? 9'h000 : qcnt + 9'h001;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         est <= pcicfg_pkg::E_START;
         qph <= 2'b00;
         step <= 4'h0;
         bitn <= 3'h7;
         shreg <= 8'h00;
         nacked <= 1'b0;
         ee_data <= 48'h0;
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
         preload_busy <= 1'b1;
      end else if (qtick && est != pcicfg_pkg::E_DONE) begin
         qph <= qph + 2'b01;
         case (est)
            pcicfg_pkg::E_START: begin
               // Release data, raise clock, pull data low, pull clock low
               sda_oe <= (qph >= 2'b10);
               scl_oe <= (qph == 2'b00) | (qph == 2'b11);
               if (qph == 2'b11) begin
                  est   <= pcicfg_pkg::E_BIT;
                  shreg <= (step == 4'h0) ? {pcicfg_pkg::EE_DEV_ADDR, 1'b0}
                                          : {pcicfg_pkg::EE_DEV_ADDR, 1'b1};
                  step  <= step + 4'h1;
               end
            end
            pcicfg_pkg::E_BIT: begin
               // Drive in quarter 0, sample in quarter 2
               scl_oe <= (qph == 2'b00) | (qph == 2'b11);
               if (qph == 2'b00) sda_oe <= (step < pcicfg_pkg::EE_STEP_RD0) & ~shreg[7];
               if (qph == 2'b10 && step >= pcicfg_pkg::EE_STEP_RD0) shreg[0] <= sda_s;
               if (qph == 2'b11) begin
                  if (bitn == 3'h0) est <= pcicfg_pkg::E_ACK;
                  else if (step < pcicfg_pkg::EE_STEP_RD0) shreg <= {shreg[6:0], 1'b0};
                  else shreg <= {shreg[6:0], 1'b0};
                  bitn <= bitn - 3'h1;
               end
            end
            pcicfg_pkg::E_ACK: begin
               scl_oe <= (qph == 2'b00) | (qph == 2'b11);
               if (qph == 2'b00) sda_oe <= (step >= pcicfg_pkg::EE_STEP_RD0)
                                        & (step != pcicfg_pkg::EE_STEP_RD0 + pcicfg_pkg::EE_NBYTES - 4'h1);
               if (qph == 2'b10 && step < pcicfg_pkg::EE_STEP_RD0 && sda_s) nacked <= 1'b1;
               if (qph == 2'b11) begin
                  if (step >= pcicfg_pkg::EE_STEP_RD0) ee_data <= {ee_data[39:0], shreg};
                  if (nacked || step == pcicfg_pkg::EE_STEP_RD0 + pcicfg_pkg::EE_NBYTES - 4'h1) begin
                     est <= pcicfg_pkg::E_STOP;
                  end else if (step == 4'h2) begin
                     est <= pcicfg_pkg::E_START; // Repeated start for reading
                  end else begin
                     est   <= pcicfg_pkg::E_BIT;
                     shreg <= (step == 4'h1) ? pcicfg_pkg::EE_WORD_ADR : 8'h00;
                     step  <= (step == 4'h1) ? 4'h2 : step + 4'h1;
                  end
               end
            end
            pcicfg_pkg::E_STOP: begin
               // Data low, clock high, data released
               sda_oe <= (qph != 2'b11) & (qph != 2'b10);
               scl_oe <= (qph == 2'b00);
               if (qph == 2'b11) begin
                  est <= pcicfg_pkg::E_DONE;
                  preload_busy <= 1'b0;
               end
            end
            default: est <= pcicfg_pkg::E_DONE;
         endcase
      end
   end

   // Loadable fields take EEPROM bytes only after a full clean read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         subsys  <= pcicfg_pkg::SUBSYS_DEF;
         max_lat <= pcicfg_pkg::MAX_LAT_DEF;
         min_gnt <= pcicfg_pkg::MIN_GNT_DEF;
      end else if (est == pcicfg_pkg::E_STOP && qtick && qph == 2'b11 && !nacked) begin
         subsys  <= ee_data[47:16];
         max_lat <= ee_data[15:8];
         min_gnt <= ee_data[7:0];
      end
   end

   // Open-drain outputs only ever pull low
   always_ff @(posedge sys_clk) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
   end
endmodule : pcicfg_target
`default_nettype wire
